// ===== eil_pkg.sv
package eil_pkg;
  localparam logic [1:0]  EIL_STATUS_CTRL_OFS = 2'h0;
  localparam int          EIL_MODE_BIT        = 0;
  localparam int          EIL_MASK_BIT        = 1;
  localparam int          EIL_CLEAR_BIT       = 2;
  localparam int          EIL_PEND_BIT        = 3;
  localparam logic [15:0] EIL_VECTOR_HI_ADDR  = 16'hFFFA;
  localparam logic [15:0] EIL_VECTOR_LO_ADDR  = 16'hFFFB;
  localparam logic [7:0]  EIL_REG_RESET       = 8'h00;
  localparam logic [1:0]  EIL_SYNC_RESET      = 2'b11;
  localparam logic [2:0]  EIL_WARM_RESET      = 3'h0;
endpackage : eil_pkg

// ===== eil_pin_if.sv
`timescale 1ns/1ps
interface eil_pin_if;
  logic pin_level;
  logic fall_edge;
  modport src (output pin_level, output fall_edge);
  modport dst (input  pin_level, input  fall_edge);
endinterface : eil_pin_if

// ===== eil_pin_sync.sv
`timescale 1ns/1ps
module eil_pin_sync
  import eil_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic irq_n,
  eil_pin_if.src    pin
);
  logic [1:0] sync_ff;
  logic       prev_ff;
  logic [2:0] warm_ff;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sync_ff <= EIL_SYNC_RESET;
      prev_ff <= 1'b1;
    end else begin
      sync_ff <= {sync_ff[0], irq_n};
      prev_ff <= sync_ff[1];
    end
  end

  // No false edge while the reset value drains out of the stages
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      warm_ff <= EIL_WARM_RESET;
    end else begin
      warm_ff <= {warm_ff[1:0], 1'b1};
    end
  end

  assign pin.pin_level = sync_ff[1];
  assign pin.fall_edge = prev_ff & ~sync_ff[1] & warm_ff[2];
endmodule : eil_pin_sync

// ===== eil_top.sv
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module eil_top
  import eil_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       irq_n,
  input  wire logic [1:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rdata,
  input  wire logic       vector_fetch_ack,
  input  wire logic       break_state,
  input  wire logic       break_clear_enable,
  output logic            irq_request,
  output logic            pin_high,
  output logic [15:0]     vector_addr
);
  import eil_pkg::*;

  eil_pin_if pin ();

  eil_pin_sync u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .irq_n    (irq_n),
    .pin      (pin)
  );

  logic mode_ff;
  logic mask_ff;
  logic latch_ff;
  logic ack_pend_ff;
  logic sel;
  logic sw_ack;
  logic ack;

  assign sel    = wr_en && (addr == EIL_STATUS_CTRL_OFS);
  // ****************************************
  // Acknowledge; register clear gated in break state, vector fetch not
  // ****************************************
  assign sw_ack = sel && wdata[EIL_CLEAR_BIT] && (!break_state || break_clear_enable);
  assign ack    = sw_ack || vector_fetch_ack;

  // ****************************************
  // Control bits
  // ****************************************
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mode_ff <= 1'b0;
      mask_ff <= 1'b0;
    end else if (sel) begin
      mode_ff <= wdata[EIL_MODE_BIT];
      mask_ff <= wdata[EIL_MASK_BIT];
    end
  end

  // ****************************************
  // Latch; a new edge wins over acknowledge
  // ****************************************
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      latch_ff    <= 1'b0;
      ack_pend_ff <= 1'b0;
    end else if (pin.fall_edge) begin
      latch_ff    <= 1'b1;
      ack_pend_ff <= 1'b0;
    end else if (!mode_ff) begin
      if (ack) begin
        latch_ff <= 1'b0;
      end
      ack_pend_ff <= 1'b0;
    end else if (latch_ff || !pin.pin_level) begin
      latch_ff <= 1'b1;
      if ((ack || ack_pend_ff) && pin.pin_level) begin
        latch_ff    <= 1'b0;
        ack_pend_ff <= 1'b0;
      end else if (ack) begin
        ack_pend_ff <= 1'b1;
      end
    end
  end

  // ****************************************
  // Outputs and read port
  // ****************************************
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      irq_request <= 1'b0;
      pin_high    <= 1'b1;
      vector_addr <= EIL_VECTOR_HI_ADDR;
      rdata       <= EIL_REG_RESET;
    end else begin
      irq_request <= latch_ff && !mask_ff;
      pin_high    <= pin.pin_level;
      vector_addr <= EIL_VECTOR_HI_ADDR;
      rdata       <= EIL_REG_RESET;
      if (rd_en && addr == EIL_STATUS_CTRL_OFS) begin
        rdata[EIL_MODE_BIT] <= mode_ff;
        rdata[EIL_MASK_BIT] <= mask_ff;
        rdata[EIL_PEND_BIT] <= latch_ff;
      end
    end
  end
endmodule : eil_top

// ===== eil_chk.sv
`timescale 1ns/1ps
module eil_chk (
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        irq_n,
  input wire logic [1:0]  addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [7:0]  rdata,
  input wire logic        vector_fetch_ack,
  input wire logic        break_state,
  input wire logic        irq_request,
  input wire logic        pin_high,
  input wire logic [15:0] vector_addr
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_vec; vector_addr == 16'hFFFA; endproperty
  a_vec: assert property (p_vec) else $error("vector address wrong");
  property p_rd; rd_en |=> rdata[2] == 1'b0; endproperty
  a_rd: assert property (p_rd) else $error("clear bit read back");
  property p_idle; !$past(rd_en) |-> rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data outside read");
  property p_plo; !irq_n [*5] |-> !pin_high; endproperty
  a_plo: assert property (p_plo) else $error("pin level not low");
  property p_phi; irq_n [*5] |-> pin_high; endproperty
  a_phi: assert property (p_phi) else $error("pin level not high");
  property p_ack;
    (irq_n && pin_high) [*4] ##0 (vector_fetch_ack || wr_en && addr == 2'h0 && wdata[2] && !break_state)
      |-> ##2 !irq_request;
  endproperty
  a_ack: assert property (p_ack) else $error("acknowledge did not clear");
  property p_mask; wr_en && addr == 2'h0 && wdata[1] |-> ##2 !irq_request; endproperty
  a_mask: assert property (p_mask) else $error("masked request shown");
  property p_rst; disable iff (1'b0) $fell(reset) |-> !irq_request && pin_high; endproperty
  a_rst: assert property (p_rst) else $error("request after reset");
  c_irq: cover property ($rose(irq_request));
  c_brk: cover property (break_state && wr_en);
  c_vf: cover property (vector_fetch_ack && irq_request);
endmodule : eil_chk
bind eil_top eil_chk u_chk (.*);

// ===== eil_pin_drv.sv
`timescale 1ns/1ps
module eil_pin_drv (
  input wire logic       core_clk,
  input wire logic [3:0] low_len,
  input wire logic       go,
  output logic           irq_n
);
  int cnt_ff = 0;
  always @(posedge core_clk) cnt_ff <= go ? int'(low_len) : (cnt_ff > 0 ? cnt_ff - 1 : 0);
  // Released pin idles high
  assign irq_n = (cnt_ff == 0);
endmodule : eil_pin_drv

// ===== external_interrupt_latch_bench.sv
`timescale 1ns/1ps
`define CHK(n,a,e) begin samples_checked++; if ((a) !== (e)) begin error_cnt++; $display("mismatch %s exp %h got %h", n, e, a); end end
module external_interrupt_latch_bench;
  logic core_clk = 0, reset = 1, irq_n, wr_en = 0, rd_en = 0, vector_fetch_ack = 0, go = 0;
  logic break_state = 0, break_clear_enable = 0, irq_request, pin_high;
  logic [1:0] addr = 2'h0;
  logic [3:0] low_len = 4'h0;
  logic [7:0] wdata = 8'h00, rdata;
  logic [15:0] vector_addr;
  logic [31:0] lf = 32'h0000_0614;
  int error_cnt = 0, samples_checked = 0, m_pend = 0, m_mask = 0, m_mode = 0;
  always #4 core_clk = ~core_clk;
  eil_top u_eil_top (.*);
  eil_pin_drv u_eil_pin_drv (.*);
  task complete_run;
    if (error_cnt == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  task tick(int n); repeat (n) @(posedge core_clk); endtask : tick
  task wr(logic [7:0] d);
    tick(1); wdata <= d; wr_en <= 1; tick(1); wr_en <= 0; m_mode = d[0]; m_mask = d[1];
  endtask : wr
  task rd;
    tick(1); rd_en <= 1; tick(1); rd_en <= 0; #1;
    `CHK("reg", rdata, 8'(m_pend * 8 + m_mask * 2 + m_mode))
    `CHK("irq", irq_request, 1'(m_pend & ~m_mask))
  endtask : rd
  task pulse(logic [3:0] n); tick(1); low_len <= n; go <= 1; tick(1); go <= 0; endtask : pulse
  task ack; tick(1); vector_fetch_ack <= 1; tick(1); vector_fetch_ack <= 0; endtask : ack
  function logic [31:0] lfsr(logic [31:0] s); return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]}; endfunction : lfsr
  initial begin
    tick(12); reset <= 0;
    rd;
    pulse(4'h3); tick(8); m_pend = 1; rd;
    wr(8'h02); tick(2); rd;
    break_state <= 1; wr(8'h04); tick(2); rd;
    break_clear_enable <= 1; wr(8'h04); m_pend = 0; tick(2); rd;
    break_state <= 0; tick(2); rd;
    wr(8'h01); pulse(4'hF); tick(6); ack; wr(8'h03); tick(2); m_pend = 1; rd;
    tick(8); m_pend = 0; rd;
    wr(8'h01); pulse(4'hF); tick(6); reset <= 1; tick(2); reset <= 0;
    m_mode = 0; m_mask = 0; m_pend = 0; tick(20); rd;
    wr(8'h00);
    repeat (4) begin
      lf = lfsr(lf); pulse(lf[3:0] | 4'h1); tick(20); m_pend = 1; rd;
      ack; tick(2); m_pend = 0; rd;
    end
    complete_run;
  end
  initial begin tick(3000); error_cnt++; complete_run; end
endmodule : external_interrupt_latch_bench
